/* File: hw/ulpi_receive_status.sv */
// Receive side of a ULPI transceiver: builds receive command bytes and
// forwards received packets to the Link over the ULPI data bus.
// Assumes the receiver front end delivers bytes on the link clock, and
// that slow configuration and status ports sit on the system clock.
//
// What this block does
// - Line state goes in bits 1:0 of every receive command.
// - Bits 3:2 encode bus power level in four bands.
// - Commands are sent on an idle bus by raising direction.
// - Event code 11 is active with error, 10 host detach.
// - Bit 6 follows the ID pin: low A-device, high B-device.
// - Bit 7 is set when an unmasked latched accessory event exists.
// - Full speed line state follows the single-ended receivers.
// - Low speed decodes alike but its idle is K.
// - High speed: 00 squelch, 01 no squelch, others invalid.
// - Chirp: 00 squelch, 01 differential high, 10 differential low.
// - A received packet follows any command transfer immediately.
// - Direction and next rising together mark receive start.
// - During receive, a cycle with next low carries a command.
// - Next is high only when a valid received byte is driven, and in the turnaround cycle that starts a receive.
// - Full speed holds receive active until line returns to idle.
// - Detach is checked only in the long end of packet after SOF.
// - A detach sends a command and sets the sticky detach bit.
// - Extended-PID power management tokens pass as normal packets.
`timescale 1ns/1ps
`default_nettype none
module ulpi_receive_status (
  input wire logic clk,
  input wire logic reset,
  input wire logic ulpi_clk,
  input wire logic [1:0] speed_mode,
  input wire logic host_mode,
  input wire logic [7:0] alt_int_latch,
  input wire logic [7:0] alt_int_mask,
  input wire logic host_detach_clear,
  output logic host_detach_event,
  input wire logic session_end_indicator,
  input wire logic session_valid_indicator,
  input wire logic bus_power_valid_indicator,
  input wire logic id_pin,
  input wire logic dp_se,
  input wire logic dm_se,
  input wire logic hs_squelch,
  input wire logic hs_diff,
  input wire logic disconnect_sense,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic reg_read_busy,
  input wire logic sof_long_eop,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe
);
  localparam int PW = rx_status_pkg::PIN_W;

  // System clock side: configuration capture and the sticky detach bit.
  typedef struct packed {
    logic [1:0] speed;
    logic host;
    logic alt_pend;
    logic tgl1;
    logic tgl2;
    logic tgl3;
    logic detach;
  } sys_s;

  // Link clock side: synchronisers, bus sequencer and event state.
  typedef struct packed {
    logic rst1;
    logic rst2;
    logic [PW-1:0] pin1;
    logic [PW-1:0] pin2;
    logic [3:0] cfg1;
    logic [3:0] cfg2;
    rx_status_pkg::bus_state_e state;
    logic dir;
    logic nxt;
    logic [7:0] data;
    logic oe;
    logic [7:0] last_cmd;
    logic rx_hold;
    logic detach_pend;
    logic detach_tgl;
    logic det_seen;
  } ulpi_s;

  sys_s s_r;
  sys_s s_nxt;
  ulpi_s u_r;
  ulpi_s u_nxt;
  line_if ln ();

  function automatic logic [1:0] vbus_code(input logic [PW-1:0] p);
    if (p[rx_status_pkg::PIN_VBUS_VLD]) begin
      vbus_code = rx_status_pkg::VBUS_ABOVE_VALID;
    end else if (p[rx_status_pkg::PIN_SESS_VLD]) begin
      vbus_code = rx_status_pkg::VBUS_VALID_TO_VBUS;
    end else if (p[rx_status_pkg::PIN_SESS_END]) begin
      vbus_code = rx_status_pkg::VBUS_BELOW_END;
    end else begin
      vbus_code = rx_status_pkg::VBUS_END_TO_VALID;
    end
  endfunction : vbus_code

  function automatic logic [1:0] evt_code(input logic detach,
                                          input logic active,
                                          input logic err);
    if (detach) begin
      evt_code = rx_status_pkg::EVT_DETACH;
    end else if (active && err) begin
      evt_code = rx_status_pkg::EVT_ACTIVE_ERR;
    end else if (active) begin
      evt_code = rx_status_pkg::EVT_ACTIVE;
    end else begin
      evt_code = rx_status_pkg::EVT_NONE;
    end
  endfunction : evt_code

  line_state_decode u_dec (
    .ulpi_clk(ulpi_clk),
    .ulpi_reset(u_r.rst2),
    .ln(ln.decoder)
  );

  assign ln.speed = u_r.cfg2[3:2];
  assign ln.dp = u_r.pin2[rx_status_pkg::PIN_DP];
  assign ln.dm = u_r.pin2[rx_status_pkg::PIN_DM];
  assign ln.squelch = u_r.pin2[rx_status_pkg::PIN_SQUELCH];
  assign ln.hs_diff = u_r.pin2[rx_status_pkg::PIN_HS_DIFF];

  // System clock domain.
  always_comb begin
    s_nxt = s_r;
    s_nxt.speed = speed_mode;
    s_nxt.host = host_mode;
    s_nxt.alt_pend = |(alt_int_latch & alt_int_mask);
    s_nxt.tgl1 = u_r.detach_tgl;
    s_nxt.tgl2 = s_r.tgl1;
    s_nxt.tgl3 = s_r.tgl2;
    s_nxt.detach = (s_r.tgl2 ^ s_r.tgl3)
                   | (s_r.detach & ~host_detach_clear);
    if (reset) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // Link clock domain.
  logic [PW-1:0] pins;
  logic [7:0] cmd;
  logic rx_rep;
  logic detect;
  logic cmd_sent;
  logic cmd_due;

  assign pins = {disconnect_sense, hs_diff, hs_squelch, dm_se, dp_se,
                 id_pin, bus_power_valid_indicator,
                 session_valid_indicator, session_end_indicator};

  always_comb begin
    u_nxt = u_r;
    // Reset is a system clock level, so it is synchronised like a pin.
    u_nxt.rst1 = reset;
    u_nxt.rst2 = u_r.rst1;
    u_nxt.pin1 = pins;
    u_nxt.pin2 = u_r.pin1;
    u_nxt.cfg1 = {s_r.speed, s_r.host, s_r.alt_pend};
    u_nxt.cfg2 = u_r.cfg1;

    rx_rep = rx_active | u_r.rx_hold;
    if (rx_active) begin
      u_nxt.rx_hold = 1'b1;
    end else if (ln.line_idle || u_r.cfg2[3:2] == rx_status_pkg::SPEED_HS
                 || u_r.cfg2[3:2] == rx_status_pkg::SPEED_CHIRP) begin
      u_nxt.rx_hold = 1'b0;
    end

    cmd[rx_status_pkg::CMD_LINE_LSB +: 2] = ln.line_state;
    cmd[rx_status_pkg::CMD_VBUS_LSB +: 2] = vbus_code(u_r.pin2);
    cmd[rx_status_pkg::CMD_EVT_LSB +: 2] =
      evt_code(u_r.detach_pend, rx_rep, rx_error);
    cmd[rx_status_pkg::CMD_ID_BIT] = u_r.pin2[rx_status_pkg::PIN_ID];
    cmd[rx_status_pkg::CMD_ALT_BIT] = u_r.cfg2[0];
    cmd_due = (cmd != u_r.last_cmd);
    cmd_sent = 1'b0;

    detect = u_r.cfg2[1] && u_r.cfg2[3:2] == rx_status_pkg::SPEED_HS
             && sof_long_eop && u_r.pin2[rx_status_pkg::PIN_DISC];

    case (u_r.state)
      rx_status_pkg::ST_IDLE: begin
        u_nxt.dir = 1'b0;
        u_nxt.nxt = 1'b0;
        u_nxt.oe = 1'b0;
        if (reg_read_busy) begin
          u_nxt.state = rx_status_pkg::ST_IDLE;
        end else if (rx_active) begin
          u_nxt.dir = 1'b1;
          u_nxt.nxt = 1'b1;
          u_nxt.state = rx_status_pkg::ST_RX_TURN;
        end else if (cmd_due) begin
          u_nxt.dir = 1'b1;
          u_nxt.state = rx_status_pkg::ST_CMD_TURN;
        end
      end
      rx_status_pkg::ST_CMD_TURN: begin
        u_nxt.nxt = 1'b0;
        u_nxt.oe = 1'b1;
        u_nxt.data = cmd;
        u_nxt.last_cmd = cmd;
        cmd_sent = 1'b1;
        u_nxt.state = rx_status_pkg::ST_CMD;
      end
      rx_status_pkg::ST_CMD: begin
        if (rx_active) begin
          u_nxt.state = rx_status_pkg::ST_RX;
          u_nxt.nxt = rx_byte_valid;
          u_nxt.data = rx_byte_valid ? rx_byte : cmd;
          u_nxt.last_cmd = rx_byte_valid ? u_r.last_cmd : cmd;
          cmd_sent = ~rx_byte_valid;
        end else if (cmd_due) begin
          u_nxt.data = cmd;
          u_nxt.last_cmd = cmd;
          cmd_sent = 1'b1;
        end else begin
          u_nxt.dir = 1'b0;
          u_nxt.oe = 1'b0;
          u_nxt.state = rx_status_pkg::ST_IDLE;
        end
      end
      rx_status_pkg::ST_RX_TURN, rx_status_pkg::ST_RX: begin
        u_nxt.oe = 1'b1;
        if (rx_byte_valid) begin
          u_nxt.nxt = 1'b1;
          u_nxt.data = rx_byte;
          u_nxt.state = rx_status_pkg::ST_RX;
        end else if (rx_rep) begin
          u_nxt.nxt = 1'b0;
          u_nxt.data = cmd;
          u_nxt.last_cmd = cmd;
          cmd_sent = 1'b1;
          u_nxt.state = rx_status_pkg::ST_RX;
        end else begin
          // Final command reports the receive as over.
          u_nxt.nxt = 1'b0;
          u_nxt.data = cmd;
          u_nxt.last_cmd = cmd;
          cmd_sent = 1'b1;
          u_nxt.state = rx_status_pkg::ST_CMD;
        end
      end
      default: begin
        u_nxt.state = rx_status_pkg::ST_IDLE;
        u_nxt.dir = 1'b0;
        u_nxt.nxt = 1'b0;
        u_nxt.oe = 1'b0;
      end
    endcase

    // detach reported once, set wins
    // Only the first cycle of a detect counts, so a window that outlasts
    // the report cannot leave the detach event stuck in later commands.
    u_nxt.det_seen = detect;
    u_nxt.detach_pend = (detect & ~u_r.det_seen)
      | (u_r.detach_pend & ~(cmd_sent
           & (cmd[rx_status_pkg::CMD_EVT_LSB +: 2]
              == rx_status_pkg::EVT_DETACH)));
    if (detect && !u_r.det_seen) begin
      u_nxt.detach_tgl = ~u_r.detach_tgl;
    end

    if (u_r.rst2) begin
      u_nxt.state = rx_status_pkg::ST_IDLE;
      u_nxt.dir = 1'b0;
      u_nxt.nxt = 1'b0;
      u_nxt.oe = 1'b0;
      u_nxt.data = 8'h00;
      u_nxt.last_cmd = rx_status_pkg::CMD_RESET;
      u_nxt.rx_hold = 1'b0;
      u_nxt.detach_pend = 1'b0;
      u_nxt.detach_tgl = 1'b0;
      u_nxt.det_seen = 1'b0;
    end
  end

  always_ff @(posedge ulpi_clk) begin
    u_r <= u_nxt;
  end

  assign host_detach_event = s_r.detach;
  assign ulpi_dir = u_r.dir;
  assign ulpi_nxt = u_r.nxt;
  assign ulpi_data_out = u_r.data;
  assign ulpi_data_oe = u_r.oe;
endmodule : ulpi_receive_status
`default_nettype wire

/* File: hw/rx_status_pkg.sv */
// Constants and types shared by the receive status logic.
// Assumes nothing of its surroundings beyond a SystemVerilog compiler.
`default_nettype none
package rx_status_pkg;
  // Operating speed as seen by the line state decoder.
  localparam logic [1:0] SPEED_FS = 2'h0;
  localparam logic [1:0] SPEED_LS = 2'h1;
  localparam logic [1:0] SPEED_HS = 2'h2;
  localparam logic [1:0] SPEED_CHIRP = 2'h3;
  // Line state codes.
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  localparam logic [1:0] LS_SE1 = 2'h3;
  // Encoded bus power levels.
  localparam logic [1:0] VBUS_BELOW_END = 2'h0;
  localparam logic [1:0] VBUS_END_TO_VALID = 2'h1;
  localparam logic [1:0] VBUS_VALID_TO_VBUS = 2'h2;
  localparam logic [1:0] VBUS_ABOVE_VALID = 2'h3;
  // Receive event codes.
  localparam logic [1:0] EVT_NONE = 2'h0;
  localparam logic [1:0] EVT_ACTIVE = 2'h1;
  localparam logic [1:0] EVT_DETACH = 2'h2;
  localparam logic [1:0] EVT_ACTIVE_ERR = 2'h3;
  // Receive command byte layout.
  localparam int CMD_LINE_LSB = 0;
  localparam int CMD_VBUS_LSB = 2;
  localparam int CMD_EVT_LSB = 4;
  localparam int CMD_ID_BIT = 6;
  localparam int CMD_ALT_BIT = 7;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam int LATCH_W = 8;
  // Pin vector bit positions.
  localparam int PIN_SESS_END = 0;
  localparam int PIN_SESS_VLD = 1;
  localparam int PIN_VBUS_VLD = 2;
  localparam int PIN_ID = 3;
  localparam int PIN_DP = 4;
  localparam int PIN_DM = 5;
  localparam int PIN_SQUELCH = 6;
  localparam int PIN_HS_DIFF = 7;
  localparam int PIN_DISC = 8;
  localparam int PIN_W = 9;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD_TURN, ST_CMD, ST_RX_TURN, ST_RX
  } bus_state_e;
endpackage : rx_status_pkg
`default_nettype wire

/* File: hw/line_if.sv */
// Carrier between the receive status top and its line state decoder.
// Assumes both ends run on the link clock.
`timescale 1ns/1ps
`default_nettype none
interface line_if;
  logic [1:0] speed;
  logic dp;
  logic dm;
  logic squelch;
  logic hs_diff;
  logic [1:0] line_state;
  logic line_idle;
  modport decoder (
    input speed, dp, dm, squelch, hs_diff,
    output line_state, line_idle
  );
  modport user (
    output speed, dp, dm, squelch, hs_diff,
    input line_state, line_idle
  );
endinterface : line_if
`default_nettype wire

/* File: hw/line_state_decode.sv */
// Registered line state decoder for full, low, high speed and chirp.
// Assumes its inputs are already synchronised to the link clock.
`timescale 1ns/1ps
`default_nettype none
module line_state_decode (
  input wire logic ulpi_clk,
  input wire logic ulpi_reset,
  line_if.decoder ln
);
  typedef struct packed {
    logic [1:0] line_state;
    logic line_idle;
  } dec_s;
  dec_s r;
  dec_s nxt;
  logic [1:0] se;

  always_comb begin
    se = {ln.dm, ln.dp};
    nxt = r;
    case (ln.speed)
      rx_status_pkg::SPEED_FS: begin
        nxt.line_state = se;
        nxt.line_idle = (se == rx_status_pkg::LS_J);
      end
      rx_status_pkg::SPEED_LS: begin
        nxt.line_state = se;
        nxt.line_idle = (se == rx_status_pkg::LS_K);
      end
      rx_status_pkg::SPEED_HS: begin
        nxt.line_state = ln.squelch ? rx_status_pkg::LS_SE0
                                    : rx_status_pkg::LS_J;
        nxt.line_idle = ln.squelch;
      end
      rx_status_pkg::SPEED_CHIRP: begin
        if (ln.squelch) begin
          nxt.line_state = rx_status_pkg::LS_SE0;
        end else if (ln.hs_diff) begin
          nxt.line_state = rx_status_pkg::LS_J;
        end else begin
          nxt.line_state = rx_status_pkg::LS_K;
        end
        nxt.line_idle = ln.squelch;
      end
      default: begin
        nxt.line_state = se;
        nxt.line_idle = 1'b0;
      end
    endcase
    if (ulpi_reset) begin
      nxt.line_state = rx_status_pkg::LS_SE0;
      nxt.line_idle = 1'b0;
    end
  end

  always_ff @(posedge ulpi_clk) begin
    r <= nxt;
  end

  assign ln.line_state = r.line_state;
  assign ln.line_idle = r.line_idle;
endmodule : line_state_decode
`default_nettype wire

/* File: test/ulpi_receive_status_checker.sv */
// Port assertions for the receive status block.
// Assumes it is bound to ulpi_receive_status.
`timescale 1ns/1ps
`default_nettype none
module ulpi_receive_status_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic ulpi_clk,
  input wire logic host_detach_clear,
  input wire logic host_detach_event,
  input wire logic disconnect_sense,
  input wire logic rx_active,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic reg_read_busy,
  input wire logic sof_long_eop,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe
);
  // Counts link cycles since a sensed detach inside the window.
  logic [5:0] since_r;
  always_ff @(posedge ulpi_clk) begin
    if (reset) begin
      since_r <= 6'h3f;
    end else if (sof_long_eop && disconnect_sense) begin
      since_r <= 6'h00;
    end else if (since_r != 6'h3f) begin
      since_r <= since_r + 6'h01;
    end
  end
  start_mark_a: assert property (@(posedge ulpi_clk) disable iff (reset)
    $rose(ulpi_dir) && ulpi_nxt |-> $past(rx_active)) else $error("bad start");
  rx_data_a: assert property (@(posedge ulpi_clk) disable iff (reset)
    ulpi_nxt && ulpi_data_oe |-> $past(rx_byte_valid)
    && ulpi_data_out == $past(rx_byte)) else $error("bad data byte");
  nxt_dir_a: assert property (@(posedge ulpi_clk) disable iff (reset)
    ulpi_nxt |-> ulpi_dir) else $error("nxt without dir");
  turn_cycle_a: assert property (@(posedge ulpi_clk) disable iff (reset)
    $rose(ulpi_dir) |-> !ulpi_data_oe) else $error("no turnaround");
  busy_block_a: assert property (@(posedge ulpi_clk) disable iff (reset)
    $rose(ulpi_dir) && !ulpi_nxt |-> !$past(reg_read_busy))
    else $error("grab while busy");
  end_event_a: assert property (@(posedge ulpi_clk) disable iff (reset)
    $fell(ulpi_dir) |-> !$past(ulpi_data_out[4])) else $error("bad last event");
  detach_window_a: assert property (@(posedge ulpi_clk) disable iff (reset)
    ulpi_data_oe && !ulpi_nxt && ulpi_data_out[5:4] == 2'h2 |-> since_r < 6'h14)
    else $error("detach outside window");
  detach_sticky_a: assert property (@(posedge clk) disable iff (reset)
    host_detach_event && !host_detach_clear |=> host_detach_event)
    else $error("detach lost");
endmodule : ulpi_receive_status_checker
`default_nettype wire

/* File: test/link_model.sv */
// Link side model: records receive commands and packet bytes.
// Assumes the ULPI outputs of the receive status block on its clock.
`timescale 1ns/1ps
`default_nettype none
module link_model (
  input wire logic ulpi_clk,
  input wire logic wipe,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe,
  output logic [7:0] last_cmd,
  output logic [3:0] evt_seen,
  output logic [7:0] n_bytes
);
  logic [7:0] pkt [16];
  // status and packet bytes kept.
  // The alt bit and line state are recorded; source lookup and
  // full speed detach timing stay with the bench.
  always @(posedge ulpi_clk) begin
    if (wipe) begin
      last_cmd <= 8'h00;
      evt_seen <= 4'h0;
      n_bytes <= 8'h00;
    end else if (ulpi_dir && ulpi_data_oe) begin
      if (ulpi_nxt) begin
        pkt[n_bytes[3:0]] <= ulpi_data_out;
        n_bytes <= n_bytes + 8'h01;
      end else begin
        last_cmd <= ulpi_data_out;
        evt_seen[ulpi_data_out[5:4]] <= 1'b1;
      end
    end
  end
endmodule : link_model
`default_nettype wire

/* File: test/ulpi_receive_status_test.sv */
// Self-checking bench for the receive status block.
// Assumes the design files and the link model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ulpi_receive_status_test;
  logic clk = 1'b0, ulpi_clk = 1'b0, reset = 1'b1, wipe = 1'b0;
  logic [1:0] speed_mode = 2'h0;
  logic host_mode = 1'b0, host_detach_clear = 1'b0, host_detach_event;
  logic [7:0] alt_int_latch = 8'h00, alt_int_mask = 8'h00, rx_byte = 8'h00;
  logic session_end_indicator = 1'b0, session_valid_indicator = 1'b0;
  logic bus_power_valid_indicator = 1'b0, id_pin = 1'b0, dp_se = 1'b0;
  logic dm_se = 1'b0, hs_squelch = 1'b0, hs_diff = 1'b0;
  logic disconnect_sense = 1'b0, rx_active = 1'b0, rx_error = 1'b0;
  logic rx_byte_valid = 1'b0, reg_read_busy = 1'b0, sof_long_eop = 1'b0;
  logic ulpi_dir, ulpi_nxt, ulpi_data_oe;
  logic [7:0] ulpi_data_out, last_cmd, n_bytes;
  logic [3:0] evt_seen;
  int bad_count = 0;
  int tests_run = 0;
  initial forever #25 clk = ~clk;
  initial begin
    #17;
    forever #62.5 ulpi_clk = ~ulpi_clk;
  end
  ulpi_receive_status uut (.clk(clk), .reset(reset), .ulpi_clk(ulpi_clk),
    .speed_mode(speed_mode), .host_mode(host_mode),
    .alt_int_latch(alt_int_latch), .alt_int_mask(alt_int_mask),
    .host_detach_clear(host_detach_clear),
    .host_detach_event(host_detach_event),
    .session_end_indicator(session_end_indicator),
    .session_valid_indicator(session_valid_indicator),
    .bus_power_valid_indicator(bus_power_valid_indicator),
    .id_pin(id_pin), .dp_se(dp_se), .dm_se(dm_se),
    .hs_squelch(hs_squelch), .hs_diff(hs_diff),
    .disconnect_sense(disconnect_sense), .rx_active(rx_active),
    .rx_error(rx_error), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .reg_read_busy(reg_read_busy), .sof_long_eop(sof_long_eop),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe));
  // The model is wiped during reset as well, so its command, event and byte count records start defined.
  link_model lk (.ulpi_clk(ulpi_clk), .wipe(wipe || reset),
    .ulpi_dir(ulpi_dir),
    .ulpi_nxt(ulpi_nxt), .ulpi_data_out(ulpi_data_out),
    .ulpi_data_oe(ulpi_data_oe), .last_cmd(last_cmd),
    .evt_seen(evt_seen), .n_bytes(n_bytes));
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic settle();
    repeat (12) @(posedge ulpi_clk);
  endtask : settle
  task automatic clear_link();
    @(posedge ulpi_clk) wipe <= 1'b1;
    @(posedge ulpi_clk) wipe <= 1'b0;
  endtask : clear_link
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic t_cmd();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      session_end_indicator <= (i == 0);
      session_valid_indicator <= (i >= 2);
      bus_power_valid_indicator <= (i == 3);
      id_pin <= i[0];
      dp_se <= i[0];
      dm_se <= i[1];
      settle();
      chk("vbus", 8'(i), 8'(last_cmd[3:2]));
      chk("line", 8'(i), 8'(last_cmd[1:0]));
      chk("id", 8'(i[0]), 8'(last_cmd[6]));
    end
    $display("test cmd done");
  endtask : t_cmd
  task automatic t_speed();
    // Entry: speed, dp, dm, squelch, diff, expected line state.
    logic [7:0] tbl [6] = '{8'h52, 8'h88, 8'h81, 8'hc5, 8'hc2, 8'hc8};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      speed_mode <= tbl[i][7:6];
      dp_se <= tbl[i][5];
      dm_se <= tbl[i][4];
      hs_squelch <= tbl[i][3];
      hs_diff <= tbl[i][2];
      settle();
      chk("state", 8'(tbl[i][1:0]), 8'(last_cmd[1:0]));
    end
    $display("test speed done");
  endtask : t_speed
  task automatic t_alt();
    @(posedge clk);
    alt_int_latch <= 8'h04;
    alt_int_mask <= 8'h04;
    settle();
    chk("alt", 8'h01, 8'(last_cmd[7]));
    @(posedge clk) alt_int_mask <= 8'h00;
    settle();
    chk("alt masked", 8'h00, 8'(last_cmd[7]));
    $display("test alt done");
  endtask : t_alt
  task automatic t_busy();
    @(posedge clk);
    speed_mode <= rx_status_pkg::SPEED_FS;
    dp_se <= 1'b1;
    dm_se <= 1'b0;
    settle();
    @(posedge ulpi_clk) reg_read_busy <= 1'b1;
    @(posedge clk) dm_se <= 1'b1;
    settle();
    chk("blocked", 8'h01, 8'(last_cmd[1:0]));
    @(posedge ulpi_clk) reg_read_busy <= 1'b0;
    settle();
    chk("released", 8'h03, 8'(last_cmd[1:0]));
    $display("test busy done");
  endtask : t_busy
  task automatic t_packet();
    // Entry: valid, error, byte; the second byte is a power token PID.
    logic [9:0] pk [5] = '{10'h2c3, 10'h000, 10'h2f0, 10'h100, 10'h255};
    @(posedge clk) dm_se <= 1'b0;
    settle();
    clear_link();
    @(posedge clk);
    dp_se <= 1'b0;
    dm_se <= 1'b1;
    @(posedge ulpi_clk) rx_active <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge ulpi_clk);
      {rx_byte_valid, rx_error, rx_byte} <= pk[i];
    end
    @(posedge ulpi_clk);
    {rx_active, rx_byte_valid, rx_error} <= 3'h0;
    dm_se <= 1'b0;
    repeat (8) @(posedge ulpi_clk);
    chk("held", 8'h01, 8'(ulpi_dir));
    @(posedge clk) dp_se <= 1'b1;
    settle();
    chk("dir end", 8'h00, 8'(ulpi_dir));
    chk("bytes", 8'h03, n_bytes);
    chk("byte0", 8'hc3, lk.pkt[0]);
    chk("token", 8'hf0, lk.pkt[1]);
    chk("byte2", 8'h55, lk.pkt[2]);
    chk("events", 8'h0b, 8'(evt_seen));
    chk("last evt", 8'h00, 8'(last_cmd[5:4]));
    $display("test packet done");
  endtask : t_packet
  task automatic t_detach();
    clear_link();
    @(posedge clk);
    host_mode <= 1'b1;
    speed_mode <= rx_status_pkg::SPEED_FS;
    disconnect_sense <= 1'b1;
    settle();
    // The Link owns detach detection in full speed, so nothing is reported.
    @(posedge ulpi_clk) sof_long_eop <= 1'b1;
    repeat (4) @(posedge ulpi_clk);
    sof_long_eop <= 1'b0;
    settle();
    chk("fs detach", 8'h00, 8'(host_detach_event));
    chk("fs detach cmd", 8'h00, 8'(evt_seen[2]));
    @(posedge clk) speed_mode <= rx_status_pkg::SPEED_HS;
    settle();
    chk("no window", 8'h00, 8'(host_detach_event));
    @(posedge ulpi_clk) sof_long_eop <= 1'b1;
    repeat (4) @(posedge ulpi_clk);
    sof_long_eop <= 1'b0;
    settle();
    chk("detach", 8'h01, 8'(host_detach_event));
    chk("detach cmd", 8'h01, 8'(evt_seen[2]));
    @(posedge clk);
    disconnect_sense <= 1'b0;
    host_detach_clear <= 1'b1;
    @(posedge clk) host_detach_clear <= 1'b0;
    settle();
    chk("cleared", 8'h00, 8'(host_detach_event));
    $display("test detach done");
  endtask : t_detach
  initial begin
    // The link side needs four of its own edges inside reset.
    repeat (4) @(posedge ulpi_clk);
    @(posedge clk) reset <= 1'b0;
    t_cmd();
    t_speed();
    t_alt();
    t_busy();
    t_packet();
    t_detach();
    close_out();
  end
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule : ulpi_receive_status_test
bind ulpi_receive_status ulpi_receive_status_checker chk_i (.clk(clk),
  .reset(reset), .ulpi_clk(ulpi_clk), .host_detach_clear(host_detach_clear),
  .host_detach_event(host_detach_event),
  .disconnect_sense(disconnect_sense), .rx_active(rx_active),
  .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
  .reg_read_busy(reg_read_busy), .sof_long_eop(sof_long_eop),
  .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
  .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe));
`default_nettype wire
